//--- bench/wrsm_assertions.sv
// wrsm_assertions.sv: port-level checker for wrsm_top, bound below
// assumes single mclk domain and srst synchronous active high
module wrsm_assertions (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        vector_load,
    input wire logic [15:0] vector_addr,
    input wire logic        cpu_clk_en,
    input wire logic        sys_clk_en,
    input wire logic        device_reset,
    input wire logic        reset_pin_oe,
    input wire logic        below_falling_trip,
    input wire logic        above_rising_trip,
    input wire logic        monitor_enable,
    input wire logic        low_supply_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ----------------------------------------------------------------
    // bus, vectors, monitor
    // ----------------------------------------------------------------
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    chk_vec_pair: assert property (vector_load |-> vector_addr[15:8] == 8'hff && !vector_addr[0])
        else $error("vector not first byte of a pair");
    chk_wake_clk: assert property (vector_load |-> cpu_clk_en)
        else $error("vector loaded with cpu clock off");
    // a reset taken in stop waits out the recovery count, so only running clocks count here
    chk_reset_vec: assert property ($rose(device_reset) && sys_clk_en
        |-> ##[0:3] (vector_load && vector_addr == 16'hfffe))
        else $error("reset without reset vector");
    chk_pin_drive: assert property ($rose(reset_pin_oe) |-> ##[0:3] device_reset)
        else $error("monitor reset not seen as device reset");
    chk_flag_set: assert property ((below_falling_trip && monitor_enable) [*4] |-> low_supply_flag)
        else $error("flag not set below trip");
    chk_flag_clr: assert property ((above_rising_trip && !below_falling_trip && monitor_enable) [*4]
        |-> !low_supply_flag)
        else $error("flag not cleared above trip");
    chk_oe_hold: assert property ((!above_rising_trip && monitor_enable) [*4] ##0 $past(reset_pin_oe)
        |-> reset_pin_oe)
        else $error("monitor reset dropped below rising trip");
    chk_oe_flag: assert property ($rose(reset_pin_oe) |-> ##[0:1] low_supply_flag)
        else $error("monitor reset without low flag");
    // main scenarios reached
    cov_wake: cover property (vector_load && vector_addr != 16'hfffe);
    cov_rst: cover property ($rose(reset_pin_oe));
    cov_flag: cover property ($fell(low_supply_flag));
endmodule

bind wrsm_top wrsm_assertions wrsm_assertions_inst (.mclk(mclk), .srst(srst),
    .hreadyout(hreadyout), .hresp(hresp), .vector_load(vector_load),
    .vector_addr(vector_addr), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .device_reset(device_reset),
    .reset_pin_oe(reset_pin_oe), .below_falling_trip(below_falling_trip),
    .above_rising_trip(above_rising_trip), .monitor_enable(monitor_enable),
    .low_supply_flag(low_supply_flag));

//--- bench/wrsm_core_model.sv
// wrsm_core_model.sv: peripheral request sources seen by the core
// assumes the bench fires one source at a time; requests clear on vector load
module wrsm_core_model (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        fire,
    input  wire logic [3:0]  src,
    input  wire logic        vector_load,
    output logic      [15:0] reqs
);
    timeunit 1ns;
    timeprecision 1ps;
    // a request level stands until the core takes a vector, like a real flag
    always @(posedge mclk) begin
        if (srst || vector_load) begin
            reqs <= 16'h0000;
        end else if (fire) begin
            reqs[src] <= 1'b1;
        end
    end
endmodule

//--- bench/wrsm_top_tb.sv
// wrsm_top_tb.sv: self-checking bench for wrsm_top
// assumes core model drives requests; reset pin has a pull-up
module wrsm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, srst = 1, hsel = 0, hwrite = 0, wait_req = 0, stop_req = 0;
    logic emu = 1, wdog = 0, kpe = 0, irq_n = 1, below = 0, above = 0, fire = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'd2;
    logic [31:0] hwdata = 0, rd, wv;
    logic [3:0] src = 0;
    wire [15:0] reqs, vaddr;
    wire [31:0] hrdata;
    wire hready, hresp, cpu_en, sys_en, vload, drst, pout, poe, mon_en, rsel, flag;
    int mismatches = 0, checks = 0, n, cyc = 0;
    initial forever #5 mclk = ~mclk;
    // ----------------------------------------------------------------
    // design and request sources
    // ----------------------------------------------------------------
    wrsm_top wrsm_top_inst (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .wait_req(wait_req),
        .stop_req(stop_req), .emulation_mode(emu), .break_req(reqs[0]),
        .watchdog_timeout(wdog), .clkgen_req(reqs[1]), .kbd_req(reqs[13]),
        .kbd_pin_edge(kpe), .timer1_req(reqs[4:2]), .timer2_req(reqs[7:5]),
        .spi_req(reqs[9:8]), .sci_req(reqs[12:10]), .adc_req(reqs[14]),
        .timebase_req(reqs[15]), .cpu_clk_en(cpu_en), .sys_clk_en(sys_en),
        .vector_load(vload), .vector_addr(vaddr), .device_reset(drst),
        .reset_pin_in(poe ? pout : 1'b1), .reset_pin_out(pout), .reset_pin_oe(poe),
        .irq_pin_n(irq_n), .below_falling_trip(below), .above_rising_trip(above),
        .monitor_enable(mon_en), .trip_range_select(rsel), .low_supply_flag(flag));
    wrsm_core_model wrsm_core_model_inst (.mclk(mclk), .srst(srst), .fire(fire),
        .src(src), .vector_load(vload), .reqs(reqs));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one ahb-lite single word transfer; read data taken at the data phase ready edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1; htrans <= 2'd2; haddr <= a; hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'd0; hsel <= 0; hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic wait_vec(input int lim);
        n = 0;
        while (vload !== 1'b1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if (vload !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: no vector load within limit", $time);
        end
    endtask
    function automatic logic [15:0] exp_vec(input int i);
        logic [15:0] t[16] = '{16'hfffc, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
            16'hffee, 16'hffec, 16'hffe8, 16'hffea, 16'hffe2, 16'hffe4, 16'hffe6,
            16'hffe0, 16'hffde, 16'hffdc};
        return (i > 15) ? 16'hfffe : t[i];
    endfunction
    // enter a low power mode, then wake it from source i (16 is the watchdog)
    task automatic wake(input int i, input logic stp);
        @(posedge mclk);
        if (stp) stop_req <= 1; else wait_req <= 1;
        @(posedge mclk);
        stop_req <= 0; wait_req <= 0;
        cycles(4);
        chk(cpu_en, 1'b0);
        @(posedge mclk);
        if (i > 15) wdog <= 1; else begin fire <= 1; src <= i[3:0]; end
        @(posedge mclk) fire <= 0;
        wait_vec(30);
        chk(vaddr, exp_vec(i));
        @(posedge mclk) wdog <= 0;
        cycles(4 + $urandom % 4);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk) if (++cyc > 60000) begin mismatches++; summarize(); end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(77930));
        repeat (4) @(posedge mclk);
        srst <= 0;
        cycles(2);
        chk(vaddr, 16'hfffe);
        chk(flag, 1'b0);
        ahb(0, 8'h0c, 0);
        chk(rd, 0);
        wv = {$urandom} & 32'h0000_003c;
        ahb(1, 8'h0c, wv);
        ahb(0, 8'h0c, 0);
        chk(rd, wv);
        chk(rsel, wv[3]);
        ahb(0, 8'h10, 0);
        chk(rd, 0);
        ahb(1, 8'h0c, 0);
        for (int i = 0; i <= 16; i++) wake(i, 0);
        repeat (20) wake($urandom % 17, 0);
        // break outside emulation leaves wait alone until emulation returns
        @(posedge mclk) begin emu <= 0; wait_req <= 1; end
        @(posedge mclk) begin wait_req <= 0; fire <= 1; src <= 4'd0; end
        @(posedge mclk) fire <= 0;
        cycles(6);
        chk(cpu_en, 1'b0);
        @(posedge mclk) emu <= 1;
        wait_vec(10);
        chk(vaddr, 16'hfffc);
        // stop: converter may not wake, irq edge then long recovery
        @(posedge mclk) stop_req <= 1;
        @(posedge mclk) stop_req <= 0;
        @(posedge mclk) begin fire <= 1; src <= 4'd14; end
        @(posedge mclk) fire <= 0;
        cycles(40);
        chk(sys_en, 1'b0);
        @(posedge mclk) irq_n <= 0;
        wait_vec(5000);
        chk(n >= 4096 && n <= 4102, 1);
        chk(vaddr, 16'hfffa);
        @(posedge mclk) irq_n <= 1;
        ahb(1, 8'h0c, 32'h0000_0010);
        @(posedge mclk) stop_req <= 1;
        @(posedge mclk) begin stop_req <= 0; fire <= 1; src <= 4'd13; kpe <= 1; end
        @(posedge mclk) begin fire <= 0; kpe <= 0; end
        wait_vec(200);
        chk(n >= 28 && n <= 38, 1);
        chk(vaddr, 16'hffe0);
        // monitor: a trip in stop ends it by reset, long recovery despite the short bit
        ahb(1, 8'h0c, 32'h0000_0014);
        @(posedge mclk) stop_req <= 1;
        @(posedge mclk) begin stop_req <= 0; below <= 1; end
        wait_vec(5000);
        chk(n >= 4096 && n <= 4106, 1);
        chk(vaddr, 16'hfffe);
        cycles(8);
        chk({flag, poe, drst}, 3'b111);
        @(posedge mclk) below <= 0;
        cycles(8);
        chk({flag, poe}, 2'b11);
        @(posedge mclk) above <= 1;
        cycles(8);
        chk({flag, poe}, 2'b00);
        cycles(8);
        ahb(1, 8'h0c, 32'h0000_0002);
        @(posedge mclk) begin below <= 1; above <= 0; end
        cycles(8);
        chk({flag, poe}, 2'b10);
        ahb(0, 8'h00, 0);
        chk(rd[0], 1'b1);
        ahb(1, 8'h0c, 32'h0000_0001);
        @(posedge mclk) begin below <= 0; above <= 1; end
        cycles(8);
        chk({mon_en, flag}, 2'b01);
        // a second reset in mid-run clears the held flag with no false trip after
        @(posedge mclk) srst <= 1;
        repeat (4) @(posedge mclk);
        srst <= 0;
        cycles(2);
        chk(flag, 1'b0);
        summarize();
    end
endmodule

//--- hw/wrsm_top.v
// wrsm_top.v: wake recovery, vector choice and supply monitor sequencing
// assumes mclk is the oscillator clock; pins and comparator outputs are async
`include "wrsm_defines.vh"

module wrsm_top (
    input  wire        mclk,
    input  wire        srst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // core side
    input  wire        wait_req,
    input  wire        stop_req,
    input  wire        emulation_mode,
    input  wire        break_req,
    input  wire        watchdog_timeout,
    input  wire        clkgen_req,
    input  wire        kbd_req,
    input  wire        kbd_pin_edge,
    input  wire [2:0]  timer1_req,
    input  wire [2:0]  timer2_req,
    input  wire [1:0]  spi_req,
    input  wire [2:0]  sci_req,
    input  wire        adc_req,
    input  wire        timebase_req,
    output reg         cpu_clk_en,
    output reg         sys_clk_en,
    output reg         vector_load,
    output reg  [15:0] vector_addr,
    output reg         device_reset,
    // pins and analog side
    input  wire        reset_pin_in,
    output wire        reset_pin_out,
    output wire        reset_pin_oe,
    input  wire        irq_pin_n,
    input  wire        below_falling_trip,
    input  wire        above_rising_trip,
    output wire        monitor_enable,
    output wire        trip_range_select,
    output wire        low_supply_flag
);

// ----------------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------------
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    reg       irq_prev_q;
    wire      rst_pin_low = ~sync2_q[0];
    wire      irq_level_n = sync2_q[1];
    wire      below_trip  = sync2_q[2];
    wire      above_trip  = sync2_q[3];
    wire      kbd_edge    = sync2_q[4];
    wire      irq_fall    = irq_prev_q & ~irq_level_n;

    // two stages each; only stage two is ever decoded
    always @(posedge mclk) begin
        if (srst) begin
            // idle levels, so no false trip or edge follows reset
            sync1_q    <= `WRSM_SYNC_IDLE;
            sync2_q    <= `WRSM_SYNC_IDLE;
            irq_prev_q <= 1'b1;
        end else begin
            sync1_q    <= {kbd_pin_edge, above_rising_trip, below_falling_trip,
                           irq_pin_n, reset_pin_in};
            sync2_q    <= sync1_q;
            irq_prev_q <= irq_level_n;
        end
    end

// ----------------------------------------------------------------------------
// option and mode registers
// ----------------------------------------------------------------------------
    reg  [5:0]  opt_q;
    reg  [1:0]  mode_q;
    reg  [15:0] last_vec_q;
    reg         flag_q;
    reg         mon_rst_q;
    reg  [11:0] rec_cnt_q;

    wire opt_pwrd   = opt_q[`WRSM_OPT_PWRD];
    wire opt_rstd   = opt_q[`WRSM_OPT_RSTD];
    wire opt_stopen = opt_q[`WRSM_OPT_STOPEN];
    wire opt_short_recovery_select  = opt_q[`WRSM_OPT_SHORT_RECOVERY_SELECT];

    // monitor powered unless disabled; in stop only with stop enable
    assign monitor_enable    = ~opt_pwrd &
                               ((mode_q != `WRSM_MODE_STOP) | opt_stopen);
    assign trip_range_select = opt_q[`WRSM_OPT_RANGE5V];
    assign low_supply_flag   = flag_q;

// ----------------------------------------------------------------------------
// ahb-lite slave: zero wait states, always okay
// ----------------------------------------------------------------------------
    reg       dp_wr_q;
    reg       dp_rd_q;
    reg [7:0] dp_addr_q;
    wire      ap_valid = hsel & htrans[1] & hready;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // latch the address phase for use in the data phase
    always @(posedge mclk) begin
        if (srst) begin
            dp_wr_q   <= 1'b0;
            dp_rd_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            dp_wr_q   <= ap_valid & hwrite;
            dp_rd_q   <= ap_valid & ~hwrite;
            dp_addr_q <= haddr;
        end
    end

    // option bits are mask-defined in silicon, here written by software
    always @(posedge mclk) begin
        if (srst) begin
            opt_q <= `WRSM_OPT_RESET;
        end else if (dp_wr_q && dp_addr_q == `WRSM_ADDR_OPTION) begin
            opt_q <= hwdata[5:0];
        end
    end

    // read data is a flop loaded at the address phase and standing through the
    // data phase; an option write ending now is forwarded so a read right
    // behind it does not return the stale word; unmapped reads zero
    wire [5:0] opt_rd = (dp_wr_q && dp_addr_q == `WRSM_ADDR_OPTION) ? hwdata[5:0] : opt_q;

    always @(posedge mclk) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            case (haddr)
                `WRSM_ADDR_STATUS: hrdata <= {30'h0000_0000, mon_rst_q, flag_q};
                `WRSM_ADDR_VECTOR: hrdata <= {16'h0000, last_vec_q};
                `WRSM_ADDR_MODE:   hrdata <= {18'h0_0000, rec_cnt_q, mode_q};
                `WRSM_ADDR_OPTION: hrdata <= {26'h000_0000, opt_rd};
                default:           hrdata <= 32'h0000_0000;
            endcase
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

// ----------------------------------------------------------------------------
// supply monitor: flag with hysteresis and held reset
// ----------------------------------------------------------------------------
    // flag and reset follow the comparators only while powered
    always @(posedge mclk) begin
        if (srst) begin
            flag_q    <= 1'b0;
            mon_rst_q <= 1'b0;
        end else if (monitor_enable) begin
            if (below_trip) begin
                flag_q    <= 1'b1;
                mon_rst_q <= ~opt_rstd;
            end else if (above_trip) begin
                flag_q    <= 1'b0;
                mon_rst_q <= 1'b0;
            end
        end else begin
            mon_rst_q <= 1'b0;
        end
    end

    // monitor reset also pulls the open-drain reset pin low
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = mon_rst_q;

// ----------------------------------------------------------------------------
// wake source priority and vector choice
// ----------------------------------------------------------------------------
    function [16:0] wrsm_pick;
        input        in_stop;
        input        brk;
        input        irq;
        input        clkg;
        input [2:0]  t1;
        input [2:0]  t2;
        input [1:0]  spi;
        input [2:0]  sci;
        input        kbd;
        input        adc;
        input        timebase_unit;
        begin
            wrsm_pick = 17'h0_0000;
            if (in_stop) begin
                // stop ends only on irq, keyboard or timebase besides resets
                if (irq)      wrsm_pick = {1'b1, `WRSM_VEC_IRQ};
                else if (kbd) wrsm_pick = {1'b1, `WRSM_VEC_KBD};
                else if (timebase_unit) wrsm_pick = {1'b1, `WRSM_VEC_TBASE};
            end else begin
                if (brk)          wrsm_pick = {1'b1, `WRSM_VEC_BREAK};
                else if (irq)     wrsm_pick = {1'b1, `WRSM_VEC_IRQ};
                else if (clkg)    wrsm_pick = {1'b1, `WRSM_VEC_CLKGEN};
                else if (t1[0])   wrsm_pick = {1'b1, `WRSM_VEC_T1CH0};
                else if (t1[1])   wrsm_pick = {1'b1, `WRSM_VEC_T1CH1};
                else if (t1[2])   wrsm_pick = {1'b1, `WRSM_VEC_T1OVF};
                else if (t2[0])   wrsm_pick = {1'b1, `WRSM_VEC_T2CH0};
                else if (t2[1])   wrsm_pick = {1'b1, `WRSM_VEC_T2CH1};
                else if (t2[2])   wrsm_pick = {1'b1, `WRSM_VEC_T2OVF};
                else if (spi[1])  wrsm_pick = {1'b1, `WRSM_VEC_SPIRX};
                else if (spi[0])  wrsm_pick = {1'b1, `WRSM_VEC_SPITX};
                else if (sci[2])  wrsm_pick = {1'b1, `WRSM_VEC_SCIERR};
                else if (sci[1])  wrsm_pick = {1'b1, `WRSM_VEC_SCIRX};
                else if (sci[0])  wrsm_pick = {1'b1, `WRSM_VEC_SCITX};
                else if (kbd)     wrsm_pick = {1'b1, `WRSM_VEC_KBD};
                else if (adc)     wrsm_pick = {1'b1, `WRSM_VEC_ADC};
                else if (timebase_unit)     wrsm_pick = {1'b1, `WRSM_VEC_TBASE};
            end
        end
    endfunction

    wire        in_stop  = (mode_q == `WRSM_MODE_STOP);
    wire        any_rst  = rst_pin_low | watchdog_timeout | mon_rst_q;
    // watchdog counter is halted in stop, so it may never end stop by itself
    wire        stop_rst = rst_pin_low | mon_rst_q;
    wire [16:0] pick     = wrsm_pick(in_stop, emulation_mode & break_req,
                                     irq_fall, clkgen_req, timer1_req,
                                     timer2_req, spi_req, sci_req,
                                     kbd_req | (in_stop & kbd_edge), adc_req,
                                     timebase_req & (~in_stop | opt_q[`WRSM_OPT_OSCRUN]));

// ----------------------------------------------------------------------------
// low-power mode sequencer
// ----------------------------------------------------------------------------
    reg  [15:0] pend_vec_q;

    // watchdog counter is halted in stop, so only pin and monitor resets end stop here
    always @(posedge mclk) begin
        if (srst) begin
            mode_q      <= `WRSM_MODE_RUN;
            rec_cnt_q   <= 12'h000;
            pend_vec_q  <= `WRSM_VEC_RESET;
            last_vec_q  <= `WRSM_VEC_RESET;
            vector_load <= 1'b0;
            vector_addr <= `WRSM_VEC_RESET;
            cpu_clk_en  <= 1'b1;
            sys_clk_en  <= 1'b1;
            device_reset <= 1'b0;
        end else begin
            vector_load  <= 1'b0;
            device_reset <= any_rst;
            case (mode_q)
                `WRSM_MODE_RUN: begin
                    cpu_clk_en <= 1'b1;
                    sys_clk_en <= 1'b1;
                    if (any_rst) begin
                        vector_load <= 1'b1;
                        vector_addr <= `WRSM_VEC_RESET;
                        last_vec_q  <= `WRSM_VEC_RESET;
                    end else if (stop_req) begin
                        mode_q     <= `WRSM_MODE_STOP;
                        cpu_clk_en <= 1'b0;
                        sys_clk_en <= 1'b0;
                    end else if (wait_req) begin
                        mode_q     <= `WRSM_MODE_WAIT;
                        cpu_clk_en <= 1'b0;
                    end
                end
                `WRSM_MODE_WAIT: begin
                    // any reset or enabled request restarts the cpu clock
                    if (any_rst || pick[16]) begin
                        mode_q      <= `WRSM_MODE_RUN;
                        cpu_clk_en  <= 1'b1;
                        vector_load <= 1'b1;
                        vector_addr <= any_rst ? `WRSM_VEC_RESET : pick[15:0];
                        last_vec_q  <= any_rst ? `WRSM_VEC_RESET : pick[15:0];
                    end
                end
                `WRSM_MODE_STOP: begin
                    if (stop_rst || pick[16]) begin
                        mode_q     <= `WRSM_MODE_RECOVER;
                        pend_vec_q <= stop_rst ? `WRSM_VEC_RESET : pick[15:0];
                        // reset exit always takes the long delay
                        rec_cnt_q  <= (stop_rst | ~opt_short_recovery_select) ?
                                      `WRSM_REC_LONG : `WRSM_REC_SHORT;
                    end
                end
                `WRSM_MODE_RECOVER: begin
                    // clocks stay inhibited until the counter runs out
                    if (rec_cnt_q == 12'h000) begin
                        mode_q      <= `WRSM_MODE_RUN;
                        cpu_clk_en  <= 1'b1;
                        sys_clk_en  <= 1'b1;
                        vector_load <= 1'b1;
                        vector_addr <= pend_vec_q;
                        last_vec_q  <= pend_vec_q;
                    end else begin
                        rec_cnt_q <= rec_cnt_q - 12'h001;
                    end
                end
                default: begin
                    mode_q <= `WRSM_MODE_RUN;
                end
            endcase
        end
    end

endmodule

//--- include/wrsm_defines.vh
// wrsm_defines.vh: constants for the wake recovery and supply monitor block
// assumes 100 MHz mclk; vectors are the high byte address of each pair
`ifndef WRSM_DEFINES_VH
`define WRSM_DEFINES_VH

// ----------------------------------------------------------------------------
// register map (byte offsets, one word apart)
// ----------------------------------------------------------------------------
`define WRSM_ADDR_STATUS    8'h00
`define WRSM_ADDR_VECTOR    8'h04
`define WRSM_ADDR_MODE      8'h08
`define WRSM_ADDR_OPTION    8'h0C

// option register bit positions
`define WRSM_OPT_PWRD       0
`define WRSM_OPT_RSTD       1
`define WRSM_OPT_STOPEN     2
`define WRSM_OPT_RANGE5V    3
`define WRSM_OPT_SHORT_RECOVERY_SELECT      4
`define WRSM_OPT_OSCRUN     5
`define WRSM_OPT_RESET      6'h00

// synchroniser idle levels: reset and irq pins high, comparators and keyboard low
`define WRSM_SYNC_IDLE      5'h03

// ----------------------------------------------------------------------------
// vector addresses (first byte of each pair)
// ----------------------------------------------------------------------------
`define WRSM_VEC_RESET      16'hFFFE
`define WRSM_VEC_BREAK      16'hFFFC
`define WRSM_VEC_IRQ        16'hFFFA
`define WRSM_VEC_CLKGEN     16'hFFF8
`define WRSM_VEC_T1CH0      16'hFFF6
`define WRSM_VEC_T1CH1      16'hFFF4
`define WRSM_VEC_T1OVF      16'hFFF2
`define WRSM_VEC_T2CH0      16'hFFF0
`define WRSM_VEC_T2CH1      16'hFFEE
`define WRSM_VEC_T2OVF      16'hFFEC
`define WRSM_VEC_SPIRX      16'hFFEA
`define WRSM_VEC_SPITX      16'hFFE8
`define WRSM_VEC_SCIERR     16'hFFE6
`define WRSM_VEC_SCIRX      16'hFFE4
`define WRSM_VEC_SCITX      16'hFFE2
`define WRSM_VEC_KBD        16'hFFE0
`define WRSM_VEC_ADC        16'hFFDE
`define WRSM_VEC_TBASE      16'hFFDC

// ----------------------------------------------------------------------------
// stop recovery counts, in oscillator cycles
// ----------------------------------------------------------------------------
`define WRSM_REC_LONG       12'hFFF
`define WRSM_REC_SHORT      12'h01F

// power modes
`define WRSM_MODE_RUN       2'h0
`define WRSM_MODE_WAIT      2'h1
`define WRSM_MODE_STOP      2'h2
`define WRSM_MODE_RECOVER   2'h3

`endif
